// *** src/simd_saturating_dsp_alu.sv ***
// Packed-lane and 32-bit saturating DSP ALU with an AXI4-Lite register file.
// Assumes one clock, a synchronous reset and an AXI4-Lite master that keeps
// at most one write and one read under way.
//
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module simd_saturating_dsp_alu
   import dsp_alu_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic sat_flag,
   output logic [3:0] lane_ge_flags
);
   state_t s_q, s_d;
   alu_op_t op;
   logic aw_take, w_take, ar_take, wr_do, wr_hit, exec, stat_wr;
   logic [DATA_W-1:0] a, b;
   logic [3:0][8:0] bsum, bdif;
   logic [1:0][16:0] hsum, hdif, xsum, xdif;
   logic [32:0] add33, sub33, dbla33, dblb33, dadd33, dsub33;
   logic [31:0] dblb;
   logic [15:0] ma, mb;
   logic signed [31:0] prod, p_ll, p_hh, p_lh, p_hl, p0, p1;
   logic [32:0] mac33;
   logic [33:0] dual34;
   logic [63:0] long64;

   assign a = s_q.op_a;
   assign b = s_q.op_b;
   assign aw_take = awvalid && s_q.awready;
   assign w_take = wvalid && s_q.wready;
   assign ar_take = arvalid && s_q.arready;
   // Both halves of a write must be held before it commits; bvalid stalls it
   assign wr_do = s_q.aw_full && s_q.w_full && !s_q.bvalid;
   assign wr_hit = s_q.aw_addr inside {OFS_OPERAND_A, OFS_OPERAND_B,
      OFS_ACC_LO, OFS_ACC_HI, OFS_COMMAND, OFS_RESULT_LO, OFS_RESULT_HI,
      OFS_STATUS};
   // The opcode byte lane must be written for the command to run
   assign exec = wr_do && s_q.aw_addr == OFS_COMMAND && s_q.w_strb[0];
   assign stat_wr = wr_do && s_q.aw_addr == OFS_STATUS;
   assign op = alu_op_t'(s_q.w_data[CMD_OP_LSB +: CMD_OP_W]);

   for (genvar i = 0; i < 4; i++) begin : g_byte
      logic [8:0] ea, eb;
      assign ea = {a[i*BYTE_W+BYTE_W-1], a[i*BYTE_W +: BYTE_W]};
      assign eb = {b[i*BYTE_W+BYTE_W-1], b[i*BYTE_W +: BYTE_W]};
      assign bsum[i] = ea + eb;
      assign bdif[i] = ea - eb;
   end

   for (genvar i = 0; i < 2; i++) begin : g_half
      localparam int J = 1 - i;
      logic [16:0] ea, eb, ex;
      assign ea = {a[i*HALF_W+HALF_W-1], a[i*HALF_W +: HALF_W]};
      assign eb = {b[i*HALF_W+HALF_W-1], b[i*HALF_W +: HALF_W]};
      assign ex = {b[J*HALF_W+HALF_W-1], b[J*HALF_W +: HALF_W]};
      assign hsum[i] = ea + eb;
      assign hdif[i] = ea - eb;
      // Crossed lanes feed every exchange form
      assign xsum[i] = ea + ex;
      assign xdif[i] = ea - ex;
   end

   assign add33 = {a[31], a} + {b[31], b};
   assign sub33 = {a[31], a} - {b[31], b};
   // Doubling goes through the same saturating add with equal inputs
   assign dbla33 = {a[31], a} + {a[31], a};
   assign dblb33 = {b[31], b} + {b[31], b};
   assign dblb = sat32(dblb33);
   assign dadd33 = {a[31], a} + {dblb[31], dblb};
   assign dsub33 = {a[31], a} - {dblb[31], dblb};

   assign ma = s_q.w_data[CMD_TOP_A] ? a[31:16] : a[15:0];
   assign mb = s_q.w_data[CMD_TOP_B] ? b[31:16] : b[15:0];
   assign prod = $signed(ma) * $signed(mb);
   assign p_ll = $signed(a[15:0]) * $signed(b[15:0]);
   assign p_hh = $signed(a[31:16]) * $signed(b[31:16]);
   assign p_lh = $signed(a[15:0]) * $signed(b[31:16]);
   assign p_hl = $signed(a[31:16]) * $signed(b[15:0]);
   assign p0 = (op == OP_DUAL_MAC_X) ? p_lh : p_ll;
   assign p1 = (op == OP_DUAL_MAC_X) ? p_hl : p_hh;
   assign mac33 = {prod[31], prod} + {s_q.acc_lo[31], s_q.acc_lo};
   // Full-precision sum; only overflow of the total past 32 bits is seen
   assign dual34 = {{2{p0[31]}}, p0} + {{2{p1[31]}}, p1}
      + {{2{s_q.acc_lo[31]}}, s_q.acc_lo};
   assign long64 = {s_q.acc_hi, s_q.acc_lo} + {{32{prod[31]}}, prod};

   always_comb begin
      logic [31:0] lo, hi, st;
      logic [3:0] ge;
      logic qset;
      lo = s_q.res_lo;
      hi = '0;
      ge = s_q.stat.ge;
      qset = 1'b0;
      st = '0;
      s_d = s_q;
      if (aw_take) begin
         s_d.aw_full = 1'b1;
         s_d.aw_addr = awaddr;
      end
      if (w_take) begin
         s_d.w_full = 1'b1;
         s_d.w_data = wdata;
         s_d.w_strb = wstrb;
      end
      if (s_q.bvalid && bready) begin
         s_d.bvalid = 1'b0;
      end
      if (wr_do) begin
         s_d.aw_full = 1'b0;
         s_d.w_full = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
         case (s_q.aw_addr)
            OFS_OPERAND_A: s_d.op_a = merge(a, s_q.w_data, s_q.w_strb);
            OFS_OPERAND_B: s_d.op_b = merge(b, s_q.w_data, s_q.w_strb);
            OFS_ACC_LO: begin
               s_d.acc_lo = merge(s_q.acc_lo, s_q.w_data, s_q.w_strb);
            end
            OFS_ACC_HI: begin
               s_d.acc_hi = merge(s_q.acc_hi, s_q.w_data, s_q.w_strb);
            end
            OFS_STATUS: begin
               st = merge(stat_image(s_q.stat), s_q.w_data, s_q.w_strb);
               s_d.stat.nzcv = st[STAT_NZCV_LSB +: 4];
               s_d.stat.q = st[STAT_Q_BIT];
               s_d.stat.ge = st[STAT_GE_LSB +: 4];
            end
            default: begin
            end
         endcase
      end
      if (exec) begin
         case (op)
            OP_SAT_ADD_BYTES, OP_SAT_SUB_BYTES: begin
               for (int i = 0; i < 4; i++) begin
                  lo[i*BYTE_W +: BYTE_W] = (op == OP_SAT_ADD_BYTES) ?
                     sat8(bsum[i]) : sat8(bdif[i]);
               end
            end
            OP_SAT_ADD_HALVES: lo = {sat16(hsum[1]), sat16(hsum[0])};
            OP_SAT_SUB_HALVES: begin
               lo = {sat16(hdif[1]), sat16(hdif[0])};
            end
            OP_SAT_SAX: lo = {sat16(xdif[1]), sat16(xsum[0])};
            OP_SAT_ASX: lo = {sat16(xsum[1]), sat16(xdif[0])};
            OP_WRAP_ASX: begin
               lo = {xsum[1][15:0], xdif[0][15:0]};
               ge = {{2{~xsum[1][16]}}, {2{~xdif[0][16]}}};
            end
            OP_WRAP_SAX: begin
               lo = {xdif[1][15:0], xsum[0][15:0]};
               ge = {{2{~xdif[1][16]}}, {2{~xsum[0][16]}}};
            end
            OP_SAT_ADD32: begin
               lo = sat32(add33);
               qset = add33[32] ^ add33[31];
            end
            OP_SAT_SUB32: begin
               lo = sat32(sub33);
               qset = sub33[32] ^ sub33[31];
            end
            OP_SAT_DADD: begin
               lo = sat32(dadd33);
               qset = (dblb33[32] ^ dblb33[31]) | (dadd33[32] ^ dadd33[31]);
            end
            OP_SAT_DSUB: begin
               lo = sat32(dsub33);
               qset = (dblb33[32] ^ dblb33[31]) | (dsub33[32] ^ dsub33[31]);
            end
            OP_SAT_DOUBLE: begin
               lo = sat32(dbla33);
               qset = dbla33[32] ^ dbla33[31];
            end
            OP_BIT_REVERSE: lo = {<<{a}};
            OP_BYTE_REVERSE: lo = {<<BYTE_W{a}};
            OP_BYTE_REVERSE_HALVES: begin
               lo = {a[23:16], a[31:24], a[7:0], a[15:8]};
            end
            OP_BYTE_REVERSE_SIGNED: begin
               lo = {{16{a[7]}}, a[7:0], a[15:8]};
            end
            OP_WRAP_ADD_HALVES, OP_WRAP_SUB_HALVES: begin
               for (int i = 0; i < 2; i++) begin
                  lo[i*HALF_W +: HALF_W] = (op == OP_WRAP_ADD_HALVES) ?
                     hsum[i][15:0] : hdif[i][15:0];
                  ge[2*i +: 2] = (op == OP_WRAP_ADD_HALVES) ?
                     {2{~hsum[i][16]}} : {2{~hdif[i][16]}};
               end
            end
            OP_WRAP_ADD_BYTES, OP_WRAP_SUB_BYTES: begin
               for (int i = 0; i < 4; i++) begin
                  lo[i*BYTE_W +: BYTE_W] = (op == OP_WRAP_ADD_BYTES) ?
                     bsum[i][7:0] : bdif[i][7:0];
                  ge[i] = (op == OP_WRAP_ADD_BYTES) ?
                     ~bsum[i][8] : ~bdif[i][8];
               end
            end
            OP_LANE_SELECT: begin
               for (int i = 0; i < 4; i++) begin
                  lo[i*BYTE_W +: BYTE_W] = s_q.stat.ge[i] ?
                     a[i*BYTE_W +: BYTE_W] : b[i*BYTE_W +: BYTE_W];
               end
            end
            // Dropping the low bit of the widened result halves it, rounding toward minus infinity
            OP_HALVING_ADD_HALVES: lo = {hsum[1][16:1], hsum[0][16:1]};
            OP_HALVING_SUB_HALVES: lo = {hdif[1][16:1], hdif[0][16:1]};
            OP_HALVING_ASX: lo = {xsum[1][16:1], xdif[0][16:1]};
            OP_HALVING_SAX: lo = {xdif[1][16:1], xsum[0][16:1]};
            OP_HALVING_ADD_BYTES, OP_HALVING_SUB_BYTES: begin
               for (int i = 0; i < 4; i++) begin
                  lo[i*BYTE_W +: BYTE_W] = (op == OP_HALVING_ADD_BYTES) ?
                     bsum[i][8:1] : bdif[i][8:1];
               end
            end
            OP_MAC_HALF: begin
               lo = mac33[31:0];
               qset = mac33[32] ^ mac33[31];
            end
            OP_DUAL_MAC, OP_DUAL_MAC_X: begin
               lo = dual34[31:0];
               qset = (dual34[33:31] != 3'b000) && (dual34[33:31] != 3'b111);
            end
            OP_LONG_MAC: begin
               {hi, lo} = long64;
            end
            default: begin
               hi = s_q.res_hi;
            end
         endcase
         s_d.res_lo = lo;
         s_d.res_hi = hi;
         s_d.stat.ge = ge;
         s_d.stat.q = s_q.stat.q | qset;
      end
      if (s_q.rvalid && rready) begin
         s_d.rvalid = 1'b0;
      end
      if (ar_take) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = RESP_OKAY;
         case (araddr)
            OFS_OPERAND_A: s_d.rdata = a;
            OFS_OPERAND_B: s_d.rdata = b;
            OFS_ACC_LO: s_d.rdata = s_q.acc_lo;
            OFS_ACC_HI: s_d.rdata = s_q.acc_hi;
            OFS_COMMAND: s_d.rdata = '0;
            OFS_RESULT_LO: s_d.rdata = s_q.res_lo;
            OFS_RESULT_HI: s_d.rdata = s_q.res_hi;
            OFS_STATUS: s_d.rdata = stat_image(s_q.stat);
            default: begin
               s_d.rdata = '0;
               s_d.rresp = RESP_SLVERR;
            end
         endcase
      end
      s_d.awready = !s_d.aw_full;
      s_d.wready = !s_d.w_full;
      s_d.arready = !s_d.rvalid;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign awready = s_q.awready;
   assign wready = s_q.wready;
   assign bvalid = s_q.bvalid;
   assign bresp = s_q.bresp;
   assign arready = s_q.arready;
   assign rvalid = s_q.rvalid;
   assign rdata = s_q.rdata;
   assign rresp = s_q.rresp;
   assign sat_flag = s_q.stat.q;
   assign lane_ge_flags = s_q.stat.ge;

   // Independent reference for the 32-bit clamp, used only by checks
   logic signed [63:0] chk_dif;
   logic [31:0] chk_sub;
   logic chk_clamp;
   assign chk_dif = 64'($signed(a)) - 64'($signed(b));
   assign chk_clamp = (chk_dif > SAT32_MAX) || (chk_dif < SAT32_MIN);
   assign chk_sub = (chk_dif > SAT32_MAX) ? SAT32_MAX[31:0] :
      (chk_dif < SAT32_MIN) ? SAT32_MIN[31:0] : chk_dif[31:0];

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_q_sticky;
      s_q.stat.q && !stat_wr |=> s_q.stat.q;
   endproperty
   a_q_sticky: assert property (p_q_sticky)
      else $error("sticky saturation flag dropped without a status write");

   property p_sat_add_bytes;
      exec && op == OP_SAT_ADD_BYTES && a[31:24] == 8'h7f && b[31:24] == 8'h01
      |=> s_q.res_lo[31:24] == 8'h7f && s_q.stat.q == $past(s_q.stat.q);
   endproperty
   a_sat_add_bytes: assert property (p_sat_add_bytes)
      else $error("byte lane add did not clamp at the positive limit");

   property p_sat_sub32;
      exec && op == OP_SAT_SUB32 |=> s_q.res_lo == $past(chk_sub)
         && s_q.stat.q == ($past(s_q.stat.q) || $past(chk_clamp));
   endproperty
   a_sat_sub32: assert property (p_sat_sub32)
      else $error("32-bit saturating subtract result or flag wrong");

   property p_bit_rev;
      exec && op == OP_BIT_REVERSE |=> s_q.res_lo[0] == $past(a[31])
         && s_q.res_lo[31] == $past(a[0]) && s_q.res_lo[30] == $past(a[1]);
   endproperty
   a_bit_rev: assert property (p_bit_rev)
      else $error("bit reverse order wrong");

   property p_byte_rev;
      exec && op == OP_BYTE_REVERSE |=> s_q.res_lo == {$past(a[7:0]),
         $past(a[15:8]), $past(a[23:16]), $past(a[31:24])};
   endproperty
   a_byte_rev: assert property (p_byte_rev)
      else $error("word byte reverse wrong");

   property p_rev_signed;
      exec && op == OP_BYTE_REVERSE_SIGNED |=> s_q.res_lo[15:0] ==
         {$past(a[7:0]), $past(a[15:8])} && s_q.res_lo[31:16] ==
         {16{s_q.res_lo[15]}};
   endproperty
   a_rev_signed: assert property (p_rev_signed)
      else $error("signed halfword reverse not sign-extended");

   property p_select;
      exec && op == OP_LANE_SELECT |=> s_q.res_lo[7:0] ==
         ($past(s_q.stat.ge[0]) ? $past(a[7:0]) : $past(b[7:0]))
         && s_q.res_lo[31:24] ==
         ($past(s_q.stat.ge[3]) ? $past(a[31:24]) : $past(b[31:24]));
   endproperty
   a_select: assert property (p_select)
      else $error("lane select picked the wrong operand");

   property p_ge_write;
      stat_wr && s_q.w_strb == 4'hf |=> s_q.stat.ge ==
         $past(s_q.w_data[19:16]) && s_q.stat.nzcv == $past(s_q.w_data[31:28]);
   endproperty
   a_ge_write: assert property (p_ge_write)
      else $error("status write did not load the flags");

   property p_wrap_ge;
      exec && op == OP_WRAP_ADD_BYTES |=> s_q.stat.ge[0] == !$past(bsum[0][8])
         && s_q.res_lo[7:0] == $past(a[7:0] + b[7:0]);
   endproperty
   a_wrap_ge: assert property (p_wrap_ge)
      else $error("wrapping byte add result or lane flag wrong");

   property p_long_mac;
      exec && op == OP_LONG_MAC |=> s_q.stat.q == $past(s_q.stat.q)
         && {s_q.res_hi, s_q.res_lo} == $past(long64);
   endproperty
   a_long_mac: assert property (p_long_mac)
      else $error("long multiply-accumulate wrong or touched the flag");

   property p_bvalid_hold;
      s_q.bvalid && !bready |=> s_q.bvalid && $stable(s_q.bresp);
   endproperty
   a_bvalid_hold: assert property (p_bvalid_hold)
      else $error("write response withdrawn before it was taken");

   c_sat_clamp: cover property (exec && op == OP_SAT_SUB32 && chk_clamp);
   c_status_write: cover property (stat_wr ##1 exec && op == OP_LANE_SELECT);
   c_dual_mac: cover property (exec && op == OP_DUAL_MAC_X);
endmodule : simd_saturating_dsp_alu
`default_nettype wire

// *** src/dsp_alu_pkg.sv ***
// Constants, types and helpers for the packed DSP ALU behind AXI4-Lite.
// Assumes a single 50 MHz clock and a synchronous, active-high reset.
// Behaviour
// - Saturating byte add clamps each of four signed lanes; lane 0 lowest.
// - Saturating byte subtract clamps each lane difference of operand one minus two.
// - Saturating halfword subtract clamps both signed 16-bit differences.
// - Saturating sub-add exchange: low = a.lo + b.hi, high = a.hi - b.lo, clamped.
// - Add-sub exchange: high = a.hi + b.lo; saturating and wrapping forms.
// - Wrapping add-sub exchange low = a.lo - b.hi and updates lane flags.
// - 32-bit saturating subtract returns a - b clamped to signed 32 bits.
// - Doubling subtract returns a - 2b, doubling and subtraction each clamped.
// - Doubling uses the saturating add with both inputs equal.
// - Any clamping 32-bit add or subtract sets the sticky saturation flag.
// - The sticky saturation flag can be read back.
// - Bit reverse swaps bit order of the whole word.
// - Word byte reverse maps bytes 3,2,1,0 to result bytes 0,1,2,3.
// - Halfword byte reverse swaps bytes inside each half independently.
// - Signed halfword reverse swaps low bytes and sign-extends the half.
// - Wrapping halfword add adds both halves without saturation.
// - Wrapping byte add adds four lanes without saturation.
// - Wrapping add, subtract and exchange update the lane flags.
// - Lane select takes each byte from a when its flag is set, else b.
// - Writing the status register loads condition flags and lane flags.
// - Halving forms return full-precision lane sum or difference divided by two.
// - Halfword multiply-accumulate sets the sticky flag when the addition overflows.
// - Dual multiply-accumulate, straight or crossed, sets the sticky flag on overflow.
// - Long multiply-accumulate into 64 bits leaves the sticky flag alone.
package dsp_alu_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned HALF_W = 16;
   localparam logic [ADDR_W-1:0] OFS_OPERAND_A = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_OPERAND_B = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_ACC_LO = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_ACC_HI = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_COMMAND = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_RESULT_LO = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_RESULT_HI = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1c;
   localparam int unsigned CMD_OP_LSB = 0;
   localparam int unsigned CMD_OP_W = 5;
   localparam int unsigned CMD_TOP_A = 8;
   localparam int unsigned CMD_TOP_B = 9;
   localparam int unsigned STAT_NZCV_LSB = 28;
   localparam int unsigned STAT_Q_BIT = 27;
   localparam int unsigned STAT_GE_LSB = 16;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic signed [63:0] SAT32_MAX = 64'sh000000007fffffff;
   localparam logic signed [63:0] SAT32_MIN = 64'shffffffff80000000;

   typedef enum logic [CMD_OP_W-1:0] {
      OP_SAT_ADD_BYTES = 5'b00000, OP_SAT_SUB_BYTES = 5'b00001,
      OP_SAT_ADD_HALVES = 5'b00010, OP_SAT_SUB_HALVES = 5'b00011,
      OP_SAT_SAX = 5'b00100, OP_SAT_ASX = 5'b00101,
      OP_WRAP_ASX = 5'b00110, OP_WRAP_SAX = 5'b00111,
      OP_SAT_ADD32 = 5'b01000, OP_SAT_SUB32 = 5'b01001,
      OP_SAT_DADD = 5'b01010, OP_SAT_DSUB = 5'b01011,
      OP_SAT_DOUBLE = 5'b01100, OP_BIT_REVERSE = 5'b01101,
      OP_BYTE_REVERSE = 5'b01110, OP_BYTE_REVERSE_HALVES = 5'b01111,
      OP_BYTE_REVERSE_SIGNED = 5'b10000, OP_WRAP_ADD_HALVES = 5'b10001,
      OP_WRAP_ADD_BYTES = 5'b10010, OP_WRAP_SUB_HALVES = 5'b10011,
      OP_WRAP_SUB_BYTES = 5'b10100, OP_LANE_SELECT = 5'b10101,
      OP_HALVING_ADD_HALVES = 5'b10110, OP_HALVING_ADD_BYTES = 5'b10111,
      OP_HALVING_SUB_HALVES = 5'b11000, OP_HALVING_SUB_BYTES = 5'b11001,
      OP_HALVING_ASX = 5'b11010, OP_HALVING_SAX = 5'b11011,
      OP_MAC_HALF = 5'b11100, OP_DUAL_MAC = 5'b11101,
      OP_DUAL_MAC_X = 5'b11110, OP_LONG_MAC = 5'b11111
   } alu_op_t;

   typedef struct packed {
      logic [3:0] nzcv;
      logic q;
      logic [3:0] ge;
   } app_status_t;

   typedef struct packed {
      logic aw_full;
      logic [ADDR_W-1:0] aw_addr;
      logic w_full;
      logic [DATA_W-1:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [DATA_W-1:0] rdata;
      logic [DATA_W-1:0] op_a;
      logic [DATA_W-1:0] op_b;
      logic [DATA_W-1:0] acc_lo;
      logic [DATA_W-1:0] acc_hi;
      logic [DATA_W-1:0] res_lo;
      logic [DATA_W-1:0] res_hi;
      app_status_t stat;
   } state_t;

   function automatic logic [7:0] sat8(input logic [8:0] v);
      return (v[8] ^ v[7]) ? {v[8], {7{~v[8]}}} : v[7:0];
   endfunction : sat8

   function automatic logic [15:0] sat16(input logic [16:0] v);
      return (v[16] ^ v[15]) ? {v[16], {15{~v[16]}}} : v[15:0];
   endfunction : sat16

   function automatic logic [31:0] sat32(input logic [32:0] v);
      return (v[32] ^ v[31]) ? {v[32], {31{~v[32]}}} : v[31:0];
   endfunction : sat32

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*BYTE_W +: BYTE_W] = nw[i*BYTE_W +: BYTE_W];
         end
      end
      return r;
   endfunction : merge

   function automatic logic [31:0] stat_image(input app_status_t s);
      logic [31:0] r;
      r = '0;
      r[STAT_NZCV_LSB +: 4] = s.nzcv;
      r[STAT_Q_BIT] = s.q;
      r[STAT_GE_LSB +: 4] = s.ge;
      return r;
   endfunction : stat_image
endpackage : dsp_alu_pkg

// *** verif/alu_host_model.sv ***
// AXI4-Lite master standing in for the decoder side of the ALU.
// Assumes clk from the bench and wr/rd called from one process only.
`timescale 1ns/1ns
`default_nettype none
module alu_host_model
   import dsp_alu_pkg::*;
(
   input wire logic clk,
   output logic [ADDR_W-1:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [DATA_W-1:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [ADDR_W-1:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   int hangs = 0;
   initial {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
   initial {araddr, arvalid, rready} = '0;
   // Each channel drops its valid at the edge that takes it
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!bvalid && n < 40) begin
         @(posedge clk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      resp = bresp;
      if (n >= 40) hangs++;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                     output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!rvalid && n < 40) begin
         @(posedge clk);
         n++;
         if (arready) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      d = rdata;
      resp = rresp;
      if (n >= 40) hangs++;
   endtask : rd
endmodule : alu_host_model
`default_nettype wire

// *** verif/simd_saturating_dsp_alu_bench.sv ***
// Self-checking bench: operations run through the register map.
// Assumes the host model for all bus traffic and a 50 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module simd_saturating_dsp_alu_bench import dsp_alu_pkg::*;;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, rdata, rv;
   logic [3:0] wstrb, lane_ge_flags;
   logic [1:0] bresp, rresp, rs;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, sat_flag;
   int error_cnt = 0;
   int checks_done = 0;
   simd_saturating_dsp_alu simd_saturating_dsp_alu_i (.clk, .rst, .awaddr,
      .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
      .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .sat_flag, .lane_ge_flags);
   alu_host_model alu_host_model_i (.clk, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
   initial forever #10 clk = ~clk;
   task automatic close_out;
      error_cnt += alu_host_model_i.hangs;
      $display("checks %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h, want %h", $time, got, exp);
      end
   endtask : chk
   task automatic put(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      alu_host_model_i.wr(a, d, rs);
      if (alu_host_model_i.hangs != 0) close_out();
   endtask : put
   task automatic get(input logic [ADDR_W-1:0] a);
      alu_host_model_i.rd(a, rv, rs);
      if (alu_host_model_i.hangs != 0) close_out();
   endtask : get
   task automatic run(input alu_op_t op, input logic [31:0] a, b, exp);
      put(OFS_OPERAND_A, a);
      put(OFS_OPERAND_B, b);
      put(OFS_COMMAND, {27'h0, op});
      get(OFS_RESULT_LO);
      chk(rv, exp);
      $display("test %s done", op.name());
   endtask : run
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk({27'h0, sat_flag, lane_ge_flags}, 32'h0);
      run(OP_SAT_ADD_BYTES, 32'h7f800102, 32'h01ff0304,
         32'h7f800406);
      run(OP_SAT_SUB_BYTES, 32'h807f0500, 32'h01ff0300,
         32'h807f0200);
      run(OP_SAT_SUB32, 32'h80000000, 32'h1, 32'h80000000);
      chk({31'h0, sat_flag}, 32'h1);
      get(OFS_STATUS);
      chk(rv, 32'h08000000);
      put(OFS_STATUS, 32'h000a0000);
      chk({27'h0, sat_flag, lane_ge_flags}, 32'h0a);
      run(OP_LANE_SELECT, 32'h11223344, 32'haabbccdd,
         32'h11bb33dd);
      run(OP_BIT_REVERSE, 32'h3, 32'h0, 32'hc0000000);
      run(OP_BYTE_REVERSE, 32'h11223344, 32'h0, 32'h44332211);
      run(OP_BYTE_REVERSE_HALVES, 32'h11223344, 32'h0,
         32'h22114433);
      run(OP_BYTE_REVERSE_SIGNED, 32'h000080ff, 32'h0,
         32'hffffff80);
      run(OP_WRAP_ADD_BYTES, 32'h7f7f0180, 32'h0101ff80,
         32'h80800000);
      chk({28'h0, lane_ge_flags}, 32'he);
      run(OP_SAT_DSUB, 32'h0, 32'h40000000, 32'h80000001);
      chk({31'h0, sat_flag}, 32'h1);
      run(OP_HALVING_SUB_BYTES, 32'h8000017f, 32'h7f010080,
         32'h80ff007f);
      put(OFS_STATUS, 32'h0);
      put(OFS_ACC_LO, 32'h7fffffff);
      run(OP_MAC_HALF, 32'h2, 32'h1, 32'h80000001);
      chk({31'h0, sat_flag}, 32'h1);
      run(OP_SAT_SUB_HALVES, 32'h80000005, 32'h00010007,
         32'h8000fffe);
      run(OP_SAT_SAX, 32'h7fff0001, 32'h0002ffff, 32'h7fff0003);
      run(OP_WRAP_ASX, 32'h00010001, 32'h00030002, 32'h0003fffe);
      chk({28'h0, lane_ge_flags}, 32'hc);
      run(OP_WRAP_ADD_HALVES, 32'h7fff0001, 32'h0001ffff,
         32'h80000000);
      run(OP_SAT_DOUBLE, 32'h40000000, 32'h0, 32'h7fffffff);
      put(OFS_ACC_LO, 32'h10);
      run(OP_DUAL_MAC_X, 32'h00020003, 32'h00040005, 32'h26);
      put(OFS_ACC_HI, 32'h1);
      put(OFS_ACC_LO, 32'hffffffff);
      run(OP_LONG_MAC, 32'hffff, 32'h2, 32'hfffffffd);
      get(OFS_RESULT_HI);
      chk(rv, 32'h1);
      chk({31'h0, sat_flag}, 32'h1);
      get(8'hfc);
      chk({30'h0, rs}, {30'h0, RESP_SLVERR});
      close_out();
   end
endmodule : simd_saturating_dsp_alu_bench
`default_nettype wire
